/* dispr_top.sv */
// Display driver state block with hardware reset defaults and register port
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Low reset forces defaults, panel off.
// - Reset selects 128 by 64 multiplex.
// - Reset restores normal segment mapping.
// - Reset restores normal row mapping.
// - Reset clears serial shift register.
// - Reset sets start line to zero.
// - Reset clears column address counter.
// - Reset selects normal common scan direction.
// - Reset loads contrast with 7Fh.
// - Reset enters normal display mode.
module dispr_top
   import dispr_pkg::*;
(
   input  wire logic                           i_clock,
   input  wire logic                           i_nrst,
   input  wire logic [dispr_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [dispr_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic                           i_wr,
   input  wire logic                           i_rd,
   output logic      [dispr_pkg::DATA_W-1:0]   o_rdata,
   input  wire logic                           i_sclk,
   input  wire logic                           i_sdin,
   input  wire logic                           i_cs_n,
   output logic                                o_panel_on,
   output logic      [dispr_pkg::MUX_W-1:0]    o_mux_ratio,
   output logic                                o_seg_remap,
   output logic                                o_com_reverse,
   output logic                                o_entire_on,
   output logic                                o_inverse,
   output logic      [dispr_pkg::DATA_W-1:0]   o_contrast,
   output logic      [dispr_pkg::LINE_W-1:0]   o_start_line,
   output logic      [dispr_pkg::COL_W-1:0]    o_col_addr,
   output logic      [dispr_pkg::DATA_W-1:0]   o_serial_byte,
   output logic                                o_serial_valid
);
   import dispr_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] byte_w;
   logic              byte_valid_w;
   logic [CNT_W-1:0]  bit_count_w;
   logic              wr_ctrl;
   logic              wr_mux;
   logic              wr_contrast;
   logic              wr_start;
   logic              wr_column;
   logic              wr_data;
   logic [COL_W-1:0]  col_d;
   logic [DATA_W-1:0] rsel;
   logic [DATA_W-1:0] ctrl_view;
   logic              first_q;

   // ----------------------------------------------------------------
   // Serial receiver
   // ----------------------------------------------------------------
   dispr_shift u_shift
   (
      .i_clock      (i_clock),
      .i_nrst       (i_nrst),
      .i_sclk       (i_sclk),
      .i_sdin       (i_sdin),
      .i_cs_n       (i_cs_n),
      .o_byte       (byte_w),
      .o_byte_valid (byte_valid_w),
      .o_bit_count  (bit_count_w)
   );

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_ctrl     = i_wr & (i_addr == OFF_CTRL);
   assign wr_mux      = i_wr & (i_addr == OFF_MUX);
   assign wr_contrast = i_wr & (i_addr == OFF_CONTRAST);
   assign wr_start    = i_wr & (i_addr == OFF_START);
   assign wr_column   = i_wr & (i_addr == OFF_COLUMN);
   assign wr_data     = i_wr & (i_addr == OFF_DATA);

   // Column write sets, data write advances and wraps after the last column
   assign col_d = wr_column ? i_wdata[COL_W-1:0] :
                  wr_data   ? ((o_col_addr == COL_LAST) ? RST_COLUMN : o_col_addr + 7'h01) :
                  o_col_addr;

   // ----------------------------------------------------------------
   // Display state
   // ----------------------------------------------------------------
   // Async reset holds every default for as long as the pin is low
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_panel_on    <= RST_PANEL_ON;
         o_mux_ratio   <= RST_MUX;
         o_seg_remap   <= RST_SEG_REMAP;
         o_com_reverse <= RST_COM_REV;
         o_entire_on   <= RST_ENTIRE;
         o_inverse     <= RST_INVERSE;
      end
      else if (wr_ctrl)
      begin
         o_panel_on    <= i_wdata[CTRL_PANEL_ON];
         o_seg_remap   <= i_wdata[CTRL_SEG_REMAP];
         o_com_reverse <= i_wdata[CTRL_COM_REV];
         o_entire_on   <= i_wdata[CTRL_ENTIRE];
         o_inverse     <= i_wdata[CTRL_INVERSE];
      end
      else if (wr_mux)
         o_mux_ratio   <= i_wdata[MUX_W-1:0];
   end

   // Addressing and contrast
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_contrast   <= RST_CONTRAST;
         o_start_line <= RST_START;
         o_col_addr   <= RST_COLUMN;
      end
      else
      begin
         o_col_addr <= col_d;
         if (wr_contrast)
            o_contrast <= i_wdata;
         if (wr_start)
            o_start_line <= i_wdata[LINE_W-1:0];
      end
   end

   // Received byte re-registered so the port comes from a flop
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_serial_byte  <= RST_BYTE;
         o_serial_valid <= 1'b0;
      end
      else
      begin
         o_serial_byte  <= byte_w;
         o_serial_valid <= byte_valid_w;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   assign ctrl_view = {3'h0, o_inverse, o_entire_on, o_com_reverse, o_seg_remap, o_panel_on};
   assign rsel = (i_addr == OFF_CTRL)     ? ctrl_view :
                 (i_addr == OFF_MUX)      ? {2'h0, o_mux_ratio} :
                 (i_addr == OFF_CONTRAST) ? o_contrast :
                 (i_addr == OFF_START)    ? {2'h0, o_start_line} :
                 (i_addr == OFF_COLUMN)   ? {1'h0, o_col_addr} :
                 (i_addr == OFF_SERIAL)   ? o_serial_byte :
                 (i_addr == OFF_SSTAT)    ? {5'h00, bit_count_w} :
                 8'h00;

   // Data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_rdata <= 8'h00;
      else
         o_rdata <= i_rd ? rsel : 8'h00;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Marks the first edge after release
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         first_q <= 1'b1;
      else
         first_q <= 1'b0;
   end

   sequence s_released;
      first_q;
   endsequence

   a_panel_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> !o_panel_on && !o_serial_valid && o_rdata == 8'h00)
      else $error("panel not off after reset");

   a_mux_default: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> o_mux_ratio == RST_MUX)
      else $error("multiplex not 64 after reset");

   a_seg_normal: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> !o_seg_remap)
      else $error("segment mapping not normal after reset");

   a_row_normal: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> !o_com_reverse && o_start_line == RST_START)
      else $error("row mapping not normal after reset");

   a_start_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> o_start_line == 6'h00)
      else $error("start line not zero after reset");

   a_col_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> o_col_addr == 7'h00)
      else $error("column counter not zero after reset");

   a_scan_normal: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released ##1 !$past(wr_ctrl) |-> !o_com_reverse)
      else $error("scan direction not normal after reset");

   a_contrast_mid: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> o_contrast == 8'h7F)
      else $error("contrast not 7Fh after reset");

   a_mode_normal: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> !o_entire_on && !o_inverse)
      else $error("display mode not normal after reset");

   a_hold_contrast: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !wr_contrast |=> $stable(o_contrast))
      else $error("contrast changed without a write");

   a_hold_col: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !(wr_column || wr_data) |=> $stable(o_col_addr))
      else $error("column changed without an access");

   a_write_takes: assert property (@(posedge i_clock) disable iff (!i_nrst)
      wr_start |=> o_start_line == $past(i_wdata[LINE_W-1:0]))
      else $error("start line write not taken");

   // ----------------------------------------------------------------
   // Checks on later commands
   // ----------------------------------------------------------------
   // Column steps after a data write; the wrap keeps the pointer inside the row
   sequence s_data_at_last;
      wr_data && o_col_addr == COL_LAST;
   endsequence

   sequence s_data_mid_row;
      wr_data && o_col_addr != COL_LAST;
   endsequence

   a_col_wrap: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_data_at_last |=> o_col_addr == RST_COLUMN)
      else $error("column did not wrap after last column");

   a_col_step: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_data_mid_row |=> o_col_addr == $past(o_col_addr) + 7'h01)
      else $error("column did not step after data write");

   a_col_set: assert property (@(posedge i_clock) disable iff (!i_nrst)
      wr_column |=> o_col_addr == $past(i_wdata[COL_W-1:0]))
      else $error("column write not taken");

   // Each command reaches its own fields and nothing else
   a_ctrl_takes: assert property (@(posedge i_clock) disable iff (!i_nrst)
      wr_ctrl |=> o_panel_on == $past(i_wdata[CTRL_PANEL_ON]) && o_inverse == $past(i_wdata[CTRL_INVERSE]))
      else $error("control write not taken");

   a_ctrl_maps: assert property (@(posedge i_clock) disable iff (!i_nrst)
      wr_ctrl |=> o_seg_remap == $past(i_wdata[CTRL_SEG_REMAP]) && o_com_reverse == $past(i_wdata[CTRL_COM_REV])
         && o_entire_on == $past(i_wdata[CTRL_ENTIRE]))
      else $error("control mapping write not taken");

   a_mux_takes: assert property (@(posedge i_clock) disable iff (!i_nrst)
      wr_mux |=> o_mux_ratio == $past(i_wdata[MUX_W-1:0]))
      else $error("multiplex write not taken");

   a_contrast_takes: assert property (@(posedge i_clock) disable iff (!i_nrst)
      wr_contrast |=> o_contrast == $past(i_wdata))
      else $error("contrast write not taken");

   a_hold_ctrl: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !wr_ctrl |=> $stable(o_panel_on) && $stable(o_com_reverse) && $stable(o_entire_on))
      else $error("control changed without a write");

   a_hold_mux: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !wr_mux |=> $stable(o_mux_ratio))
      else $error("multiplex changed without a write");

   a_hold_start: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !wr_start |=> $stable(o_start_line))
      else $error("start line changed without a write");

   // Read data last one cycle so a stale value never looks fresh
   a_rdata_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data stood past its cycle");

   // Bytes and bit counts start clean after release
   a_serial_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
      s_released |-> o_serial_byte == RST_BYTE && bit_count_w == RST_COUNT)
      else $error("serial state not cleared by reset");

   a_serial_pass: assert property (@(posedge i_clock) disable iff (!i_nrst)
      byte_valid_w |=> o_serial_valid && o_serial_byte == $past(byte_w))
      else $error("received byte not passed on");

endmodule // dispr_top

/* dispr_pkg.sv */
// Package of register map, field layout and reset defaults for the display reset-defaults block
package dispr_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 8;
   localparam int MUX_W   = 6;
   localparam int LINE_W  = 6;
   localparam int COL_W   = 7;
   localparam int CNT_W   = 3;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_MUX      = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_CONTRAST = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_START    = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_COLUMN   = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_DATA     = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_SERIAL   = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_SSTAT    = 4'h7;

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTRL_PANEL_ON = 0;
   localparam int CTRL_SEG_REMAP = 1;
   localparam int CTRL_COM_REV  = 2;
   localparam int CTRL_ENTIRE   = 3;
   localparam int CTRL_INVERSE  = 4;

   // ----------------------------------------------------------------
   // Reset defaults
   // ----------------------------------------------------------------
   localparam logic              RST_PANEL_ON = 1'b0;
   localparam logic              RST_SEG_REMAP = 1'b0;
   localparam logic              RST_COM_REV  = 1'b0;
   localparam logic              RST_ENTIRE   = 1'b0;
   localparam logic              RST_INVERSE  = 1'b0;
   localparam logic [MUX_W-1:0]  RST_MUX      = 6'h3F;
   localparam logic [DATA_W-1:0] RST_CONTRAST = 8'h7F;
   localparam logic [LINE_W-1:0] RST_START    = 6'h00;
   localparam logic [COL_W-1:0]  RST_COLUMN   = 7'h00;
   localparam logic [COL_W-1:0]  COL_LAST     = 7'h7F;
   localparam logic [DATA_W-1:0] RST_BYTE     = 8'h00;
   localparam logic [CNT_W-1:0]  RST_COUNT    = 3'h0;

endpackage

/* dispr_shift.sv */
// Serial host shift register with pin synchronisers
`timescale 1ns/1ps
module dispr_shift
   import dispr_pkg::*;
(
   input  wire logic                           i_clock,
   input  wire logic                           i_nrst,
   input  wire logic                           i_sclk,
   input  wire logic                           i_sdin,
   input  wire logic                           i_cs_n,
   output logic      [dispr_pkg::DATA_W-1:0]   o_byte,
   output logic                                o_byte_valid,
   output logic      [dispr_pkg::CNT_W-1:0]    o_bit_count
);
   import dispr_pkg::*;

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic [2:0]        meta_q;
   logic [2:0]        sync_q;
   logic              sclk_old_q;
   logic [DATA_W-1:0] shift_q;
   logic [DATA_W-1:0] shift_d;
   logic [CNT_W-1:0]  count_q;
   logic              last_bit;
   logic              sclk_rise;

   // Two stages per pin; only the second stage feeds logic
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         meta_q     <= 3'h7;
         sync_q     <= 3'h7;
         sclk_old_q <= 1'b1;
      end
      else
      begin
         meta_q     <= {i_cs_n, i_sdin, i_sclk};
         sync_q     <= meta_q;
         sclk_old_q <= sync_q[0];
      end
   end

   // ----------------------------------------------------------------
   // Shifting
   // ----------------------------------------------------------------
   assign sclk_rise = sync_q[0] & ~sclk_old_q & ~sync_q[2];
   assign last_bit  = (count_q == 3'h7);
   assign shift_d   = {shift_q[DATA_W-2:0], sync_q[1]};

   // Deselect drops a partial byte so framing recovers on next select
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         shift_q      <= RST_BYTE;
         count_q      <= RST_COUNT;
         o_byte       <= RST_BYTE;
         o_byte_valid <= 1'b0;
      end
      else
      begin
         o_byte_valid <= sclk_rise & last_bit;
         if (sync_q[2])
            count_q <= RST_COUNT;
         else if (sclk_rise)
         begin
            shift_q <= shift_d;
            count_q <= count_q + 3'h1;
            if (last_bit)
               o_byte <= shift_d;
         end
      end
   end

   assign o_bit_count = count_q;

   // Bit count leaves reset at zero
   logic first_q;
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         first_q <= 1'b1;
      else
         first_q <= 1'b0;
   end

   a_shift_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
      first_q |-> (count_q == RST_COUNT && shift_q == RST_BYTE))
      else $error("shift register not cleared by reset");

   a_deselect_drop: assert property (@(posedge i_clock) disable iff (!i_nrst)
      sync_q[2] |=> (count_q == RST_COUNT))
      else $error("partial byte kept after deselect");

endmodule // dispr_shift

/* dispr_host_model.sv */
// Host-side model that drives the reset pin and the serial select, clock and data pins
`timescale 1ns/1ps
module dispr_host_model
(
   input  wire logic i_clock,
   output logic      o_nrst,
   output logic      o_sclk,
   output logic      o_sdin,
   output logic      o_cs_n
);

   // ----------------------------------------------------------------
   // Pin levels at time zero
   // ----------------------------------------------------------------
   // Reset is asserted and the link is idle with its clock standing still
   initial
   begin
      o_nrst = 1'b0;
      o_sclk = 1'b0;
      o_sdin = 1'b1;
      o_cs_n = 1'b1;
   end

   // ----------------------------------------------------------------
   // Reset pin
   // ----------------------------------------------------------------
   // Pulled low to recover from a corrupted image, or at start-up
   task automatic begin_reset();
      @(posedge i_clock);
      o_nrst <= 1'b0;
   endtask

   // Release; the caller decides how long the pin stayed low
   task automatic end_reset();
      @(posedge i_clock);
      o_nrst <= 1'b1;
   endtask

   // ----------------------------------------------------------------
   // Serial link
   // ----------------------------------------------------------------
   // MSB first; four cycles per phase keeps clear of the synchronisers
   task automatic send_bits(input logic [7:0] value, input int count);
      int i;
      @(posedge i_clock);
      o_cs_n <= 1'b0;
      for (i = 0; i < count; i++)
      begin
         o_sdin <= value[7-i];
         repeat (4) @(posedge i_clock);
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_clock);
         o_sclk <= 1'b0;
      end
   endtask

   // Deselect; data no longer holds its last value once released
   task automatic end_frame();
      repeat (4) @(posedge i_clock);
      o_cs_n <= 1'b1;
      o_sdin <= ~o_sdin;
   endtask

endmodule // dispr_host_model

/* dispr_top_tb_top.sv */
// Self-checking testbench for the display reset-defaults block
`timescale 1ns/1ps
module dispr_top_tb_top;
   import dispr_pkg::*;

   logic              clock;
   logic              nrst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              sclk;
   logic              sdin;
   logic              cs_n;
   logic              o_panel_on;
   logic [MUX_W-1:0]  o_mux_ratio;
   logic              o_seg_remap;
   logic              o_com_reverse;
   logic              o_entire_on;
   logic              o_inverse;
   logic [DATA_W-1:0] o_contrast;
   logic [LINE_W-1:0] o_start_line;
   logic [COL_W-1:0]  o_col_addr;
   logic [DATA_W-1:0] o_serial_byte;
   logic              o_serial_valid;
   int                fails;
   int                samples_checked;
   int                valid_pulses;
   logic [DATA_W-1:0] seen;

   // ----------------------------------------------------------------
   // Clock, bus idle levels and instances
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial
   begin
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      fails = 0;
      samples_checked = 0;
      valid_pulses = 0;
   end

   dispr_host_model host_u (.i_clock(clock), .o_nrst(nrst), .o_sclk(sclk), .o_sdin(sdin), .o_cs_n(cs_n));

   dispr_top dut_u (.i_clock(clock), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_sclk(sclk), .i_sdin(sdin), .i_cs_n(cs_n), .o_panel_on(o_panel_on),
      .o_mux_ratio(o_mux_ratio), .o_seg_remap(o_seg_remap), .o_com_reverse(o_com_reverse),
      .o_entire_on(o_entire_on), .o_inverse(o_inverse), .o_contrast(o_contrast), .o_start_line(o_start_line),
      .o_col_addr(o_col_addr), .o_serial_byte(o_serial_byte), .o_serial_valid(o_serial_valid));

   // Every completed byte must show up as exactly one pulse
   always @(posedge clock)
      if (o_serial_valid === 1'b1)
         valid_pulses++;

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Panel state pins against expected control, mux, contrast, start and column
   task automatic check_pins(input logic [7:0] c, m, k, s, l);
      check("panel_on", 8'(o_panel_on), 8'(c[0]));
      check("seg_remap", 8'(o_seg_remap), 8'(c[1]));
      check("com_reverse", 8'(o_com_reverse), 8'(c[2]));
      check("entire_on", 8'(o_entire_on), 8'(c[3]));
      check("inverse", 8'(o_inverse), 8'(c[4]));
      check("mux_ratio", 8'(o_mux_ratio), m);
      check("contrast", o_contrast, k);
      check("start_line", 8'(o_start_line), s);
      check("col_addr", 8'(o_col_addr), l);
   endtask

   task automatic check_defaults();
      check_pins(8'h00, 8'h3F, 8'h7F, 8'h00, 8'h00);
      check("serial_byte", o_serial_byte, 8'h00);
   endtask

   // Register view of the defaults, including an unmapped index
   task automatic check_default_regs();
      logic [3:0] a [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hF};
      logic [7:0] e [8] = '{8'h00, 8'h3F, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] d;
      for (int i = 0; i < 8; i++)
      begin
         rd_reg(a[i], d);
         check("default register", d, e[i]);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      // Defaults must show while the pin is still low
      repeat (10) @(posedge clock);
      #1 check_defaults();
      repeat (9) @(posedge clock);
      host_u.end_reset();
      #1 check_defaults();
      check_default_regs();
      // Every field away from its default, then readback with an idle cycle between read strobes
      wr_reg(OFF_CTRL, 8'h1F);
      wr_reg(OFF_MUX, 8'h1F);
      wr_reg(OFF_CONTRAST, 8'h22);
      wr_reg(OFF_START, 8'h15);
      wr_reg(OFF_COLUMN, 8'h40);
      #1 check_pins(8'h1F, 8'h1F, 8'h22, 8'h15, 8'h40);
      rd_reg(OFF_CTRL, seen);
      check("control readback", seen, 8'h1F);
      rd_reg(OFF_MUX, seen);
      check("mux readback", seen, 8'h1F);
      rd_reg(OFF_START, seen);
      check("start readback", seen, 8'h15);
      @(posedge clock);
      #1 check("read data after its cycle", rdata, 8'h00);
      // Data writes step the column and wrap after the last one; the data index reads as zero
      wr_reg(OFF_COLUMN, {1'b0, COL_LAST});
      wr_reg(OFF_DATA, 8'hAA);
      #1 check("col after wrap", 8'(o_col_addr), 8'h00);
      wr_reg(OFF_DATA, 8'h55);
      #1 check("col after step", 8'(o_col_addr), 8'h01);
      rd_reg(OFF_DATA, seen);
      check("data index", seen, 8'h00);
      host_u.send_bits(8'hA5, 8);
      host_u.end_frame();
      repeat (8) @(posedge clock);
      check("serial_byte", o_serial_byte, 8'hA5);
      check("valid pulses", 8'(valid_pulses), 8'h01);
      // Partial byte, then reset in mid-frame with the select held low
      host_u.send_bits(8'hE0, 3);
      repeat (6) @(posedge clock);
      rd_reg(OFF_SSTAT, seen);
      check("bits collected", seen, 8'h03);
      host_u.begin_reset();
      repeat (3) @(posedge clock);
      #1 check_defaults();
      repeat (16) @(posedge clock);
      host_u.end_reset();
      repeat (6) @(posedge clock);
      rd_reg(OFF_SSTAT, seen);
      check("bits after reset", seen, 8'h00);
      // Five more bits must not complete the discarded byte
      host_u.send_bits(8'hF8, 5);
      repeat (8) @(posedge clock);
      check("valid pulses", 8'(valid_pulses), 8'h01);
      host_u.end_frame();
      // Defaults hold with no commands, then a command still lands
      repeat (50) @(posedge clock);
      #1 check_defaults();
      check_default_regs();
      wr_reg(OFF_CONTRAST, 8'h01);
      #1 check("contrast", o_contrast, 8'h01);
      give_verdict();
   end

   // Whole run is about 320 cycles; this span is far beyond it
   initial
   begin
      repeat (20000) @(posedge clock);
      fails++;
      give_verdict();
   end

endmodule // dispr_top_tb_top
